// file: rtl/supervision_counter_defines.vh
// Purpose: Constants for the index-port supervision counter
// Assumes: 125 MHz system clock
// Notes:   Offsets are index values written through the address port
`ifndef SUPERVISION_COUNTER_DEFINES_VH
`define SUPERVISION_COUNTER_DEFINES_VH

// ----------------------------------------------------------------
// Port selection and key values
// ----------------------------------------------------------------
`define SC_PORT_ADDR      1'b0
`define SC_PORT_DATA      1'b1
`define SC_KEY_UNLOCK     8'h87
`define SC_KEY_LOCK       8'hAA
`define SC_LDEV_NUM       8'h08
`define SC_ACT_ON         8'h01

// ----------------------------------------------------------------
// Register indexes
// ----------------------------------------------------------------
`define SC_IDX_LDEV       8'h07
`define SC_IDX_ACT        8'h30
`define SC_IDX_UNIT       8'hF0
`define SC_IDX_COUNT      8'hF1
`define SC_IDX_CTRL       8'hF2

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SC_UNIT_MIN_BIT   3
`define SC_CTRL_MOUSE_BIT 7
`define SC_CTRL_KBD_BIT   6
`define SC_CTRL_FORCE_BIT 5
`define SC_CTRL_STAT_BIT  4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SC_RST_BYTE       8'h00

// ----------------------------------------------------------------
// Timing: one second and sixty seconds at 125 MHz
// ----------------------------------------------------------------
`define SC_CLK_HZ         125000000
`define SC_SEC_CYCLES     (`SC_CLK_HZ * 1)
`define SC_MIN_SECONDS    60

`endif

// file: rtl/index_port_watchdog_timer.v
// Purpose: Supervision counter reached through an index/data port pair
// Assumes: Host port strobes are synchronous one-cycle pulses; mouse and
//          keyboard activity arrive from pins and are synchronised here
// Notes:   Timeout output is a level held until the count is rewritten
//
// Notes on behaviour
// RQ1: Host writes an index to the address port, then accesses data port.
// RQ2: Two successive unlock key writes to the address port unlock access.
// RQ3: Lock key on the address port relocks until the next unlock.
// RQ4: Writing the device number to select register maps indexes here.
// RQ5: Counter runs only when activation register holds one; off at reset.
// RQ6: Unit register bit 3 picks seconds (0, default) or minutes (1).
// RQ7: Count register holds interval; zero stops, 1 to 255 sets interval.
// RQ8: Any write to the count register restarts countdown from new value.
// RQ9: Interval expiry without restart raises the timeout output.
// RQ10: Control bit 7 lets mouse activity restart the count; reset clear.
// RQ11: Control bit 6 lets keyboard activity restart the count; reset clear.
// RQ12: Writing one to control bit 5 forces timeout, then self-clears.
// RQ13: Control bit 4 reads one once timeout has been reached.
// RQ14: Data port writes are ignored while the device is locked.
`timescale 1ns/1ps
`include "supervision_counter_defines.vh"

module index_port_watchdog_timer (
  // Clock, reset, enable
  input  wire       i_sys_clk,
  input  wire       i_nrst,
  input  wire       i_ce,
  // Host port access
  input  wire       i_port_sel,
  input  wire       i_wr,
  input  wire       i_rd,
  input  wire [7:0] i_wdata,
  output reg  [7:0] o_rdata,
  // Activity pins
  input  wire       i_mouse_act,
  input  wire       i_kbd_act,
  // Timeout
  output reg        o_timeout
);

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  // Counts are worked out wide, then cut to the bits the counters hold
  localparam [31:0] SEC_WIDE = `SC_SEC_CYCLES - 1;
  localparam [31:0] MIN_WIDE = `SC_MIN_SECONDS - 1;
  localparam [26:0] SEC_LAST = SEC_WIDE[26:0];
  localparam [5:0]  MIN_LAST = MIN_WIDE[5:0];
  localparam        ST_LOCKED = 2'b00;
  localparam        ST_HALF   = 2'b01;
  localparam        ST_OPEN   = 2'b10;

  function is_idx;
    input [7:0] idx;
    input [7:0] want;
    begin
      is_idx = (idx == want);
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [1:0]  key_ff;
  reg [7:0]  index_ff;
  reg [7:0]  ldev_ff;
  reg [7:0]  act_ff;
  reg [7:0]  unit_ff;
  reg [7:0]  count_ff;
  reg        mouse_en_ff;
  reg        kbd_en_ff;
  reg [7:0]  remain_ff;
  reg [26:0] tick_ff;
  reg [5:0]  sec_ff;
  reg [1:0]  mouse_sync_ff;
  reg [1:0]  kbd_sync_ff;
  reg        mouse_prev_ff;
  reg        kbd_prev_ff;

  wire open_acc  = (key_ff == ST_OPEN);
  wire addr_wr   = i_wr && (i_port_sel == `SC_PORT_ADDR);
  // Locked data writes are dropped outright [RQ14]
  wire data_wr   = i_wr && (i_port_sel == `SC_PORT_DATA) && open_acc;
  wire dev_sel   = (ldev_ff == `SC_LDEV_NUM);                   // [RQ4]
  wire reg_wr    = data_wr && dev_sel;
  wire running   = (act_ff == `SC_ACT_ON);                      // [RQ5]
  wire wr_count  = reg_wr && is_idx(index_ff, `SC_IDX_COUNT);
  wire wr_ctrl   = reg_wr && is_idx(index_ff, `SC_IDX_CTRL);
  wire force_to  = wr_ctrl && i_wdata[`SC_CTRL_FORCE_BIT];      // [RQ12]
  // Rising edges only, so a held line restarts once, not forever
  wire mouse_evt = mouse_sync_ff[1] && !mouse_prev_ff;
  wire kbd_evt   = kbd_sync_ff[1] && !kbd_prev_ff;
  wire kick      = (mouse_en_ff && mouse_evt)                   // [RQ10]
                 || (kbd_en_ff && kbd_evt);                     // [RQ11]
  wire use_min   = unit_ff[`SC_UNIT_MIN_BIT];                   // [RQ6]
  wire sec_tick  = (tick_ff == SEC_LAST);
  wire unit_tick = sec_tick && (!use_min || sec_ff == MIN_LAST);

  // ----------------------------------------------------------------
  // Key sequence and index latch
  // ----------------------------------------------------------------
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      key_ff   <= ST_LOCKED;
      index_ff <= `SC_RST_BYTE;
    end else if (i_ce && addr_wr) begin
      if (i_wdata == `SC_KEY_LOCK) begin
        key_ff <= ST_LOCKED;                                    // [RQ3]
      end else begin
        case (key_ff)
          ST_LOCKED: key_ff <= (i_wdata == `SC_KEY_UNLOCK) ?
                               ST_HALF : ST_LOCKED;             // [RQ2]
          ST_HALF:   key_ff <= (i_wdata == `SC_KEY_UNLOCK) ?
                               ST_OPEN : ST_LOCKED;             // [RQ2]
          ST_OPEN:   key_ff <= ST_OPEN;
          default:   key_ff <= ST_LOCKED;
        endcase
        if (open_acc) begin
          index_ff <= i_wdata;                                  // [RQ1]
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ldev_ff     <= `SC_RST_BYTE;
      act_ff      <= `SC_RST_BYTE;
      unit_ff     <= `SC_RST_BYTE;
      count_ff    <= `SC_RST_BYTE;
      mouse_en_ff <= 1'b0;
      kbd_en_ff   <= 1'b0;
    end else if (i_ce) begin
      if (data_wr && is_idx(index_ff, `SC_IDX_LDEV)) begin
        ldev_ff <= i_wdata;                                     // [RQ4]
      end
      if (reg_wr && is_idx(index_ff, `SC_IDX_ACT)) begin
        act_ff <= i_wdata;                                      // [RQ5]
      end
      if (reg_wr && is_idx(index_ff, `SC_IDX_UNIT)) begin
        unit_ff <= i_wdata;                                     // [RQ6]
      end
      if (wr_count) begin
        count_ff <= i_wdata;                                    // [RQ7]
      end
      if (wr_ctrl) begin
        mouse_en_ff <= i_wdata[`SC_CTRL_MOUSE_BIT];             // [RQ10]
        kbd_en_ff   <= i_wdata[`SC_CTRL_KBD_BIT];               // [RQ11]
      end
    end
  end

  // ----------------------------------------------------------------
  // Activity synchronisers
  // ----------------------------------------------------------------
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mouse_sync_ff <= 2'h0;
      kbd_sync_ff   <= 2'h0;
      mouse_prev_ff <= 1'b0;
      kbd_prev_ff   <= 1'b0;
    end else if (i_ce) begin
      mouse_sync_ff <= {mouse_sync_ff[0], i_mouse_act};
      kbd_sync_ff   <= {kbd_sync_ff[0], i_kbd_act};
      mouse_prev_ff <= mouse_sync_ff[1];
      kbd_prev_ff   <= kbd_sync_ff[1];
    end
  end

  // ----------------------------------------------------------------
  // Countdown
  // ----------------------------------------------------------------
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      remain_ff <= `SC_RST_BYTE;
      tick_ff   <= 27'h0;
      sec_ff    <= 6'h0;
      o_timeout <= 1'b0;
    end else if (i_ce) begin
      if (force_to) begin
        o_timeout <= 1'b1;                                      // [RQ12]
      end else if (wr_count) begin
        // Rewriting the count also clears a pending timeout
        remain_ff <= i_wdata;                                   // [RQ8]
        tick_ff   <= 27'h0;
        sec_ff    <= 6'h0;
        o_timeout <= 1'b0;
      end else if (kick && !o_timeout) begin
        remain_ff <= count_ff;                                  // [RQ10]
        tick_ff   <= 27'h0;
        sec_ff    <= 6'h0;
      end else if (running && remain_ff != 8'h00 && !o_timeout) begin
        // Zero count leaves the counter stopped [RQ7]
        tick_ff <= sec_tick ? 27'h0 : tick_ff + 27'h1;
        if (sec_tick) begin
          sec_ff <= (sec_ff == MIN_LAST) ? 6'h0 : sec_ff + 6'h1;
        end
        if (unit_tick) begin
          remain_ff <= remain_ff - 8'h1;
          if (remain_ff == 8'h01) begin
            o_timeout <= 1'b1;                                  // [RQ9]
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= `SC_RST_BYTE;
    end else if (i_ce && i_rd) begin
      if (i_port_sel == `SC_PORT_ADDR || !open_acc) begin
        o_rdata <= open_acc ? index_ff : `SC_RST_BYTE;
      end else if (is_idx(index_ff, `SC_IDX_LDEV)) begin
        o_rdata <= ldev_ff;
      end else if (!dev_sel) begin
        o_rdata <= `SC_RST_BYTE;
      end else if (is_idx(index_ff, `SC_IDX_ACT)) begin
        o_rdata <= act_ff;
      end else if (is_idx(index_ff, `SC_IDX_UNIT)) begin
        o_rdata <= unit_ff;
      end else if (is_idx(index_ff, `SC_IDX_COUNT)) begin
        o_rdata <= count_ff;
      end else if (is_idx(index_ff, `SC_IDX_CTRL)) begin
        o_rdata <= {mouse_en_ff, kbd_en_ff, 1'b0, o_timeout,
                    4'h0};                                      // [RQ13]
      end else begin
        o_rdata <= `SC_RST_BYTE;
      end
    end
  end

endmodule // index_port_watchdog_timer

// file: bench/sc_monitor.sv
// Purpose: Port checker for the supervision counter
// Assumes: One clock, asynchronous active-low reset
// Notes:   Shadows lock state and index from host traffic
`timescale 1ns/1ps
`include "supervision_counter_defines.vh"
module sc_monitor (
  // Ports watched
  input wire       i_sys_clk,
  input wire       i_nrst,
  input wire       i_ce,
  input wire       i_port_sel,
  input wire       i_wr,
  input wire       i_rd,
  input wire [7:0] i_wdata,
  input wire [7:0] o_rdata,
  input wire       o_timeout
);
  // ---------------
  // Shadow state
  // ---------------
  reg       open_ff;
  reg       key1_ff;
  reg [7:0] idx_ff;
  reg [7:0] ldev_ff;
  reg [7:0] cnt_ff;
  reg [1:0] en_ff;
  wire aw = i_ce && i_wr && i_port_sel == `SC_PORT_ADDR;
  wire dw = i_ce && i_wr && i_port_sel == `SC_PORT_DATA && open_ff;
  wire ok = open_ff && ldev_ff == `SC_LDEV_NUM;
  wire ow = dw && ok;
  wire dr = i_ce && i_rd && i_port_sel == `SC_PORT_DATA && ok;
  wire fw = ow && idx_ff == `SC_IDX_CTRL && i_wdata[5];
  wire cw = ow && idx_ff == `SC_IDX_COUNT;
  wire rc = dr && idx_ff == `SC_IDX_COUNT;
  wire rf = dr && idx_ff == `SC_IDX_CTRL;
  always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      open_ff <= 1'b0;
      key1_ff <= 1'b0;
      idx_ff  <= 8'h00;
      ldev_ff <= 8'h00;
      cnt_ff  <= 8'h00;
      en_ff   <= 2'h0;
    end else begin
      if (aw) key1_ff <= i_wdata == `SC_KEY_UNLOCK;
      if (aw && i_wdata == `SC_KEY_LOCK) open_ff <= 1'b0;
      else if (aw && key1_ff && i_wdata == `SC_KEY_UNLOCK) open_ff <= 1'b1;
      if (aw && open_ff && i_wdata != `SC_KEY_LOCK) idx_ff <= i_wdata;
      if (dw && idx_ff == `SC_IDX_LDEV) ldev_ff <= i_wdata;
      if (cw) cnt_ff <= i_wdata;
      if (ow && idx_ff == `SC_IDX_CTRL) en_ff <= i_wdata[7:6];
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  a_force_timeout: assert property (fw |=> o_timeout)
    else $error("forced timeout missing");
  a_locked_read: assert property (i_ce && i_rd && !open_ff |=>
    o_rdata == 8'h00) else $error("locked read not zero");
  a_count_clear: assert property (cw && !fw |=> !o_timeout)
    else $error("count write kept timeout");
  a_rdata_hold: assert property (!(i_ce && i_rd) |=> $stable(o_rdata))
    else $error("read data moved");
  a_timeout_hold: assert property (o_timeout && !cw |=> o_timeout)
    else $error("timeout dropped");
  a_status_read: assert property (rf |=> o_rdata[4] == $past(o_timeout)
    && !o_rdata[5]) else $error("status bits wrong");
  a_count_read: assert property (rc |=> o_rdata == $past(cnt_ff))
    else $error("count readback wrong");
  a_enable_read: assert property (rf |=> o_rdata[7:6] == $past(en_ff))
    else $error("enable bits wrong");
  c_force: cover property (fw);
  c_count: cover property (rc);
  c_locked: cover property (i_ce && i_rd && !open_ff);
endmodule // sc_monitor

// file: bench/host_port.sv
// Purpose: Host software model driving the address and data ports
// Assumes: Strobes launched just after a rising edge
// Notes:   Idle write data is inverted so stale values never pass
`timescale 1ns/1ps
module host_port (
  // Port pair
  input  wire       i_sys_clk,
  input  wire [7:0] i_rdata,
  output reg        o_port_sel,
  output reg        o_wr,
  output reg        o_rd,
  output reg  [7:0] o_wdata
);
  // ---------------
  // Port cycles
  // ---------------
  initial o_port_sel = 1'b0;
  initial o_wr = 1'b0;
  initial o_rd = 1'b0;
  initial o_wdata = 8'h00;
  task put(input reg sel, input reg [7:0] val); begin
    @(posedge i_sys_clk);
    o_port_sel <= sel;
    o_wdata <= val;
    o_wr <= 1'b1;
    @(posedge i_sys_clk);
    o_wr <= 1'b0;
    o_wdata <= ~val;
  end endtask
  task get(output reg [7:0] val); begin
    @(posedge i_sys_clk);
    o_port_sel <= 1'b1;
    o_rd <= 1'b1;
    @(posedge i_sys_clk);
    o_rd <= 1'b0;
    @(posedge i_sys_clk);
    val = i_rdata;
  end endtask
  task unlock; begin
    put(1'b0, 8'h87);
    put(1'b0, 8'h87);
  end endtask
  task reg_wr(input reg [7:0] idx, input reg [7:0] val); begin
    put(1'b0, idx);
    put(1'b1, val);
  end endtask
  task reg_rd(input reg [7:0] idx, output reg [7:0] val); begin
    put(1'b0, idx);
    get(val);
  end endtask
endmodule // host_port

// file: bench/tb.sv
// Purpose: Self-checking bench for the supervision counter
// Assumes: Long counts untested; forced timeout used instead
// Notes:   Activity pins and clock enable held steady
`timescale 1ns/1ps
module tb;
  // ---------------
  // Harness
  // ---------------
  reg        clk = 1'b0;
  reg        nrst = 1'b0;
  wire       port_sel;
  wire       wr;
  wire       rd;
  wire [7:0] wdata;
  wire [7:0] rdata;
  wire       timeout;
  reg  [7:0] v;
  integer    error_cnt = 0;
  integer    comparisons = 0;
  always #4 clk = ~clk;
  index_port_watchdog_timer dut (.i_sys_clk(clk), .i_nrst(nrst), .i_ce(1'b1),
    .i_port_sel(port_sel), .i_wr(wr), .i_rd(rd), .i_wdata(wdata),
    .o_rdata(rdata), .i_mouse_act(1'b0), .i_kbd_act(1'b0), .o_timeout(timeout));
  host_port host (.i_sys_clk(clk), .i_rdata(rdata), .o_port_sel(port_sel),
    .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
  task chk8(input string what, input reg [7:0] exp, input reg [7:0] got); begin
    comparisons = comparisons + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  end endtask
  task chk_to(input reg exp); begin
    @(posedge clk);
    chk8("timeout", {7'h00, exp}, {7'h00, timeout});
  end endtask
  task conclude; begin
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  end endtask
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt = error_cnt + 1;
    conclude;
  end
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    chk_to(1'b0);
    host.reg_rd(8'hF1, v);
    chk8("locked read", 8'h00, v);
    host.put(1'b0, 8'h87);
    host.put(1'b0, 8'h00);
    host.put(1'b0, 8'h87);
    host.reg_rd(8'hF1, v);
    chk8("broken unlock", 8'h00, v);
    host.unlock;
    host.reg_wr(8'h07, 8'h08);
    host.reg_wr(8'h30, 8'h01);
    host.reg_rd(8'hF1, v);
    chk8("count reset", 8'h00, v);
    host.reg_rd(8'hF2, v);
    chk8("ctrl reset", 8'h00, v);
    host.reg_wr(8'hF1, 8'h10);
    host.reg_rd(8'hF1, v);
    chk8("count", 8'h10, v);
    host.reg_wr(8'hF2, 8'hE0);
    chk_to(1'b1);
    host.reg_rd(8'hF2, v);
    chk8("ctrl status", 8'hD0, v);
    host.reg_wr(8'hF1, 8'h05);
    chk_to(1'b0);
    host.reg_wr(8'hF0, 8'h08);
    host.reg_rd(8'hF0, v);
    chk8("unit", 8'h08, v);
    host.reg_rd(8'h30, v);
    chk8("activate", 8'h01, v);
    // Index left on control, so a leaked write would force a timeout
    host.put(1'b0, 8'hF2);
    host.put(1'b0, 8'hAA);
    host.put(1'b1, 8'h20);
    chk_to(1'b0);
    host.get(v);
    chk8("relocked read", 8'h00, v);
    // Count is nonzero now, so a false unlock would show in the read
    host.put(1'b0, 8'h87);
    host.put(1'b0, 8'h00);
    host.put(1'b0, 8'h87);
    host.reg_rd(8'hF1, v);
    chk8("broken unlock data", 8'h00, v);
    host.unlock;
    host.reg_wr(8'h07, 8'h00);
    host.reg_wr(8'hF1, 8'h33);
    host.reg_wr(8'h07, 8'h08);
    host.reg_rd(8'hF1, v);
    chk8("other device", 8'h05, v);
    host.reg_wr(8'hF2, 8'h20);
    chk_to(1'b1);
    // Second reset in mid-run: all registers and the timeout go back
    @(posedge clk);
    nrst <= 1'b0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    chk_to(1'b0);
    host.unlock;
    host.reg_wr(8'h07, 8'h08);
    host.reg_rd(8'h30, v);
    chk8("activate after reset", 8'h00, v);
    host.reg_rd(8'hF0, v);
    chk8("unit after reset", 8'h00, v);
    host.reg_rd(8'hF1, v);
    chk8("count after reset", 8'h00, v);
    host.reg_rd(8'hF2, v);
    chk8("ctrl after reset", 8'h00, v);
    conclude;
  end
endmodule // tb
bind index_port_watchdog_timer sc_monitor mon (.i_sys_clk(i_sys_clk),
  .i_nrst(i_nrst), .i_ce(i_ce), .i_port_sel(i_port_sel), .i_wr(i_wr),
  .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_timeout(o_timeout));
